// ---- inc/bridge_ctrl_defines.svh ----
// offsets, field positions, reset values and timing counts of the bridge control registers
`ifndef BRIDGE_CTRL_DEFINES_SVH
`define BRIDGE_CTRL_DEFINES_SVH

`define CHIP_CONTROL_OFS 8'h40
`define DIAGNOSTIC_CONTROL_OFS 8'h41
`define POWER_DATA_BYTE_OFS 8'he3
`define CTRL_DWORD 6'h10
`define POWER_DWORD 6'h38

`define MEM_WR_DISC_BIT 1
`define PREFETCH_DIS_BIT 4
`define CHIP_RESET_BIT 8
`define TEST_MODE_LO 9
`define TEST_MODE_HI 10

`define MEM_WR_DISC_RST 1'b0
`define PREFETCH_DIS_RST 1'b0
`define TEST_MODE_RST 2'h0

`define CLOCK_PERIOD_NS 50
`define CHIP_RESET_NS 1000
`define CHIP_RESET_CYCLES ((`CHIP_RESET_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ---- inc/bridge_ctrl_pkg.sv ----
// types shared by the bridge control register files
package bridge_ctrl_pkg;

  typedef struct packed {
    logic write;
    logic [5:0] dword;
    logic [3:0] be_l;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef enum logic [1:0] {
    RD_MEM = 2'b00,
    RD_MEM_LINE = 2'b01,
    RD_MEM_MULT = 2'b10,
    RD_OTHER = 2'b11
  } read_cmd_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RESET = 1'b1
  } reset_state_e;

endpackage : bridge_ctrl_pkg

// ---- hw/chip_reset_seq.sv ----
// chip reset sequencer: holds the internal reset for a fixed time
`include "bridge_ctrl_defines.svh"

module chip_reset_seq (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  output logic busy_o
);

  localparam logic [7:0] LAST_COUNT = 8'(`CHIP_RESET_CYCLES - 1);

  bridge_ctrl_pkg::reset_state_e state_reg, state_next;
  logic [7:0] count_reg, count_next;
  logic busy_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      bridge_ctrl_pkg::SEQ_IDLE: begin
        count_next = 8'h00;
        if (start_i) begin
          state_next = bridge_ctrl_pkg::SEQ_RESET;
        end
      end
      bridge_ctrl_pkg::SEQ_RESET: begin
        // a second start during the sequence is absorbed
        if (count_reg == LAST_COUNT) begin
          state_next = bridge_ctrl_pkg::SEQ_IDLE;
        end else begin
          count_next = count_reg + 8'h01;
        end
      end
    endcase
    busy_next = (state_next == bridge_ctrl_pkg::SEQ_RESET);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= bridge_ctrl_pkg::SEQ_IDLE;
      count_reg <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      busy_o <= busy_next;
    end
  end

endmodule : chip_reset_seq

// ---- hw/bridge_chip_control_regs.sv ----
// device-specific chip control and diagnostic control registers of the bridge
//
// Summary of operation
// - The top byte of the power management dword always reads zero.
// - Writes change only the bytes whose active-low byte enable is low.
// - Reserved fields and registers are read-only and read as zero.
// - With write disconnect control clear, memory writes disconnect only on queue full or a 4KB boundary.
// - With write disconnect control set, memory writes also disconnect at each cache line boundary.
// - With prefetch disable clear, upstream memory reads prefetch and byte enables are not forwarded.
// - With prefetch disable set, upstream memory reads fetch one dword and forward the read byte enables.
// - With prefetch disable set, the requesting master gets a target disconnect on the first data transfer.
// - Memory read line and memory read multiple remain prefetchable regardless of prefetch disable.
// - Writing one to the chip reset bit starts a chip reset; writing zero does nothing.
// - Setting chip reset also asserts secondary bus reset and sets the secondary reset bit.
// - The two-bit test mode selects which counter bytes are exercised: 00 all, 01 byte 1, 10 byte 2, 11 byte 0.
`include "bridge_ctrl_defines.svh"

module bridge_chip_control_regs (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // configuration access
  input wire logic cfg_valid_i,
  input wire bridge_ctrl_pkg::cfg_req_s cfg_req_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // target memory write
  input wire logic tw_active_i,
  input wire logic tw_queue_full_i,
  input wire logic [11:0] tw_addr_i,
  input wire logic [7:0] cache_line_dw_i,
  output logic tw_disconnect_o,
  // upstream memory read
  input wire logic ur_valid_i,
  input wire bridge_ctrl_pkg::read_cmd_e ur_cmd_i,
  output logic ur_prefetch_o,
  output logic ur_single_dword_o,
  output logic ur_forward_be_o,
  output logic ur_disconnect_first_o,
  // chip and secondary reset
  input wire logic sec_reset_clear_i,
  output logic chip_reset_o,
  output logic sec_rst_l_o,
  output logic sec_reset_bit_o,
  // counter test
  output logic [1:0] test_mode_o,
  output logic [2:0] counter_byte_en_o
);

  // register state
  logic mem_wr_disc_reg, mem_wr_disc_next;
  logic prefetch_dis_reg, prefetch_dis_next;
  logic [1:0] test_mode_reg, test_mode_next;
  logic sec_reset_reg, sec_reset_next;
  logic chip_start;
  logic chip_busy;
  logic ctrl_hit;
  logic ctrl_wr;

  assign ctrl_hit = cfg_req_i.dword == `CTRL_DWORD;
  assign ctrl_wr = cfg_valid_i && cfg_req_i.write && ctrl_hit;

  // sequencer runs the fixed-length internal reset
  chip_reset_seq u_chip_reset_seq (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(chip_start),
    .busy_o(chip_busy)
  );

  always_comb begin
    mem_wr_disc_next = mem_wr_disc_reg;
    prefetch_dis_next = prefetch_dis_reg;
    test_mode_next = test_mode_reg;
    sec_reset_next = sec_reset_reg;
    chip_start = 1'b0;
    if (chip_busy) begin
      // configuration is held at its initial state while the chip resets
      mem_wr_disc_next = `MEM_WR_DISC_RST;
      prefetch_dis_next = `PREFETCH_DIS_RST;
      test_mode_next = `TEST_MODE_RST;
    end else if (ctrl_wr) begin
      // a start only counts while idle, so a repeat write cannot stretch the reset
      if (!cfg_req_i.be_l[0]) begin
        // bits 0, 3:2 and 7:5 are dropped silently
        mem_wr_disc_next = cfg_req_i.wdata[`MEM_WR_DISC_BIT];
        prefetch_dis_next = cfg_req_i.wdata[`PREFETCH_DIS_BIT];
      end
      if (!cfg_req_i.be_l[1]) begin
        test_mode_next = cfg_req_i.wdata[`TEST_MODE_HI:`TEST_MODE_LO];
        chip_start = cfg_req_i.wdata[`CHIP_RESET_BIT];
      end
    end
    // set wins over a clear arriving in the same cycle
    if (sec_reset_clear_i) begin
      sec_reset_next = 1'b0;
    end
    if (chip_start) begin
      sec_reset_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mem_wr_disc_reg <= `MEM_WR_DISC_RST;
      prefetch_dis_reg <= `PREFETCH_DIS_RST;
      test_mode_reg <= `TEST_MODE_RST;
      sec_reset_reg <= 1'b0;
    end else begin
      mem_wr_disc_reg <= mem_wr_disc_next;
      prefetch_dis_reg <= prefetch_dis_next;
      test_mode_reg <= test_mode_next;
      sec_reset_reg <= sec_reset_next;
    end
  end

  // read path and acknowledge
  logic cfg_ack_next;
  logic [31:0] cfg_rdata_next;

  always_comb begin
    cfg_ack_next = cfg_valid_i;
    cfg_rdata_next = 32'h0000_0000;
    if (cfg_valid_i && !cfg_req_i.write && ctrl_hit) begin
      cfg_rdata_next[`MEM_WR_DISC_BIT] = mem_wr_disc_reg;
      cfg_rdata_next[`PREFETCH_DIS_BIT] = prefetch_dis_reg;
      // reads one until the sequencer finishes
      cfg_rdata_next[`CHIP_RESET_BIT] = chip_busy;
      cfg_rdata_next[`TEST_MODE_HI:`TEST_MODE_LO] = test_mode_reg;
    end
    // byte enables do not trim reads; the whole dword returns
    // power dword: top data byte is never implemented, stays zero
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o <= cfg_ack_next;
      cfg_rdata_o <= cfg_rdata_next;
    end
  end

  // target write disconnect decision
  logic last_in_4k;
  logic last_in_line;
  logic [7:0] line_mask;
  logic tw_disconnect_next;

  always_comb begin
    // cache line size is assumed a power of two in dwords
    // other sizes give ragged disconnect points, never an error
    line_mask = cache_line_dw_i - 8'h01;
    last_in_4k = &tw_addr_i[11:2];
    last_in_line = (cache_line_dw_i != 8'h00) &&
      ((tw_addr_i[9:2] & line_mask) == line_mask);
    tw_disconnect_next = tw_active_i && !chip_busy &&
      (tw_queue_full_i || last_in_4k ||
      (mem_wr_disc_reg && last_in_line));
  end

  // upstream read prefetch policy
  // line and multiple reads keep prefetching so bulk moves stay fast
  logic prefetchable;
  logic ur_prefetch_next;
  logic ur_single_next;

  always_comb begin
    prefetchable = !prefetch_dis_reg ||
      (ur_cmd_i == bridge_ctrl_pkg::RD_MEM_LINE) ||
      (ur_cmd_i == bridge_ctrl_pkg::RD_MEM_MULT);
    ur_prefetch_next = ur_valid_i && !chip_busy && prefetchable;
    ur_single_next = ur_valid_i && !chip_busy && !prefetchable;
  end

  // counter byte select for chip test
  // decoded from the held mode, so it trails test_mode_o by one cycle
  logic [2:0] byte_en_next;

  always_comb begin
    unique case (test_mode_reg)
      2'h0: byte_en_next = 3'h7;
      2'h1: byte_en_next = 3'h2;
      2'h2: byte_en_next = 3'h4;
      2'h3: byte_en_next = 3'h1;
    endcase
  end

  // all block outputs come from flops so other logic sees no decode glitches
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tw_disconnect_o <= 1'b0;
      ur_prefetch_o <= 1'b0;
      ur_single_dword_o <= 1'b0;
      ur_forward_be_o <= 1'b0;
      ur_disconnect_first_o <= 1'b0;
      chip_reset_o <= 1'b0;
      sec_rst_l_o <= 1'b1;
      sec_reset_bit_o <= 1'b0;
      test_mode_o <= `TEST_MODE_RST;
      counter_byte_en_o <= 3'h7;
    end else begin
      tw_disconnect_o <= tw_disconnect_next;
      ur_prefetch_o <= ur_prefetch_next;
      ur_single_dword_o <= ur_single_next;
      ur_forward_be_o <= ur_single_next;
      ur_disconnect_first_o <= ur_single_next;
      // buffers and both bus interfaces reset from this output
      chip_reset_o <= chip_busy;
      // taken from the next value so it falls with the start edge
      sec_rst_l_o <= !sec_reset_next;
      sec_reset_bit_o <= sec_reset_next;
      test_mode_o <= test_mode_next;
      counter_byte_en_o <= byte_en_next;
    end
  end

endmodule : bridge_chip_control_regs

// ---- test/bridge_chip_control_regs_properties.sv ----
// assertions on the chip control register ports
module chip_ctrl_check (
  // clock and config
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_valid_i,
  input wire bridge_ctrl_pkg::cfg_req_s cfg_req_i,
  input wire logic cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  // traffic policy
  input wire logic tw_active_i,
  input wire logic tw_queue_full_i,
  input wire logic tw_disconnect_o,
  input wire logic ur_valid_i,
  input wire bridge_ctrl_pkg::read_cmd_e ur_cmd_i,
  input wire logic ur_prefetch_o,
  input wire logic ur_single_dword_o,
  input wire logic ur_forward_be_o,
  input wire logic ur_disconnect_first_o,
  // resets and test
  input wire logic sec_reset_clear_i,
  input wire logic chip_reset_o,
  input wire logic sec_rst_l_o,
  input wire logic sec_reset_bit_o,
  input wire logic [1:0] test_mode_o,
  input wire logic [2:0] counter_byte_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_rst_wr;
    cfg_valid_i && cfg_req_i.write && cfg_req_i.dword == 6'h10 && !cfg_req_i.be_l[1] && cfg_req_i.wdata[8] &&
      !chip_reset_o && !$past(cfg_valid_i && cfg_req_i.write && cfg_req_i.dword == 6'h10 &&
      !cfg_req_i.be_l[1] && cfg_req_i.wdata[8]);
  endsequence
  sequence s_rst_go;
    ##1 (!sec_rst_l_o && sec_reset_bit_o) ##1 chip_reset_o;
  endsequence
  property p_ack; cfg_valid_i |=> cfg_ack_o; endproperty
  property p_pwr; cfg_valid_i && cfg_req_i.dword == 6'h38 |=> cfg_rdata_o == 32'h0; endproperty
  property p_rsv; cfg_ack_o |-> (cfg_rdata_o & 32'hffff_f8ed) == 32'h0; endproperty
  property p_full; tw_active_i && tw_queue_full_i |=> tw_disconnect_o || chip_reset_o; endproperty
  property p_idle; !tw_active_i |=> !tw_disconnect_o; endproperty
  property p_line; ur_valid_i && ur_cmd_i inside {bridge_ctrl_pkg::RD_MEM_LINE, bridge_ctrl_pkg::RD_MEM_MULT}
    |=> ur_prefetch_o || chip_reset_o; endproperty
  property p_single; ur_single_dword_o == ur_forward_be_o && ur_forward_be_o == ur_disconnect_first_o; endproperty
  property p_start; s_rst_wr |-> s_rst_go; endproperty
  property p_len; $rose(chip_reset_o) |-> ##19 chip_reset_o ##1 !chip_reset_o; endproperty
  property p_hold; !sec_rst_l_o && !sec_reset_clear_i |=> !sec_rst_l_o; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  a_pwr: assert property (p_pwr) else $error("power dword not zero");
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  a_full: assert property (p_full) else $error("no disconnect on full queue");
  a_idle: assert property (p_idle) else $error("disconnect while idle");
  a_line: assert property (p_line) else $error("line read not prefetched");
  a_single: assert property (p_single) else $error("single dword outputs differ");
  a_start: assert property (p_start) else $error("chip reset start wrong");
  a_len: assert property (p_len) else $error("chip reset length wrong");
  a_hold: assert property (p_hold) else $error("secondary reset released early");
endmodule : chip_ctrl_check

bind bridge_chip_control_regs chip_ctrl_check u_check (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .cfg_valid_i(cfg_valid_i),
  .cfg_req_i(cfg_req_i),
  .cfg_ack_o(cfg_ack_o),
  .cfg_rdata_o(cfg_rdata_o),
  .tw_active_i(tw_active_i),
  .tw_queue_full_i(tw_queue_full_i),
  .tw_disconnect_o(tw_disconnect_o),
  .ur_valid_i(ur_valid_i),
  .ur_cmd_i(ur_cmd_i),
  .ur_prefetch_o(ur_prefetch_o),
  .ur_single_dword_o(ur_single_dword_o),
  .ur_forward_be_o(ur_forward_be_o),
  .ur_disconnect_first_o(ur_disconnect_first_o),
  .sec_reset_clear_i(sec_reset_clear_i),
  .chip_reset_o(chip_reset_o),
  .sec_rst_l_o(sec_rst_l_o),
  .sec_reset_bit_o(sec_reset_bit_o),
  .test_mode_o(test_mode_o),
  .counter_byte_en_o(counter_byte_en_o)
);

// ---- test/host_clear_model.sv ----
// host model: clears the secondary reset bit on request
module host_clear_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // request and strobe
  input wire logic clear_req_i,
  output logic sec_reset_clear_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clear_reg;
  always_ff @(posedge clock_i) clear_reg <= !rst_i && clear_req_i;
  assign sec_reset_clear_o = clear_reg;
endmodule : host_clear_model

// ---- test/bridge_chip_control_regs_bench.sv ----
// self-checking bench of the chip control registers
module bridge_chip_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, rst_i = 1'b1, cfg_valid_i = 1'b0, tw_active_i = 1'b0, tw_queue_full_i = 1'b0;
  logic ur_valid_i = 1'b0, clear_req = 1'b0, sec_reset_clear_i, cfg_ack_o, tw_disconnect_o;
  logic ur_prefetch_o, ur_single_dword_o, ur_forward_be_o, ur_disconnect_first_o;
  logic chip_reset_o, sec_rst_l_o, sec_reset_bit_o;
  logic [11:0] tw_addr_i = 12'h000;
  logic [7:0] cache_line_dw_i = 8'h04;
  logic [31:0] cfg_rdata_o;
  logic [1:0] test_mode_o;
  logic [2:0] counter_byte_en_o;
  bridge_ctrl_pkg::cfg_req_s cfg_req_i = '0;
  bridge_ctrl_pkg::read_cmd_e ur_cmd_i = bridge_ctrl_pkg::RD_MEM;
  int bad_count = 0, n_checks = 0;
  bridge_chip_control_regs u_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_valid_i(cfg_valid_i),
    .cfg_req_i(cfg_req_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .tw_active_i(tw_active_i),
    .tw_queue_full_i(tw_queue_full_i), .tw_addr_i(tw_addr_i), .cache_line_dw_i(cache_line_dw_i),
    .tw_disconnect_o(tw_disconnect_o), .ur_valid_i(ur_valid_i), .ur_cmd_i(ur_cmd_i),
    .ur_prefetch_o(ur_prefetch_o), .ur_single_dword_o(ur_single_dword_o), .ur_forward_be_o(ur_forward_be_o),
    .ur_disconnect_first_o(ur_disconnect_first_o), .sec_reset_clear_i(sec_reset_clear_i),
    .chip_reset_o(chip_reset_o), .sec_rst_l_o(sec_rst_l_o), .sec_reset_bit_o(sec_reset_bit_o),
    .test_mode_o(test_mode_o), .counter_byte_en_o(counter_byte_en_o));
  host_clear_model u_host (.clock_i(clock_i), .rst_i(rst_i), .clear_req_i(clear_req),
    .sec_reset_clear_o(sec_reset_clear_i));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one access per two cycles, sampled at the negedge after the ack edge
  task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be_l, input logic [31:0] d);
    @(posedge clock_i);
    cfg_valid_i <= 1'b1;
    cfg_req_i <= '{wr, dw, be_l, d};
    @(posedge clock_i);
    cfg_valid_i <= 1'b0;
    @(negedge clock_i);
    chk({31'h0, cfg_ack_o}, 32'h1);
  endtask : cfg
  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    cfg(1'b0, dw, 4'h0, 32'h0);
    chk(cfg_rdata_o, exp);
  endtask : rd
  task automatic tw(input logic full, input logic [11:0] a, input logic exp);
    @(posedge clock_i);
    tw_active_i <= 1'b1;
    tw_queue_full_i <= full;
    tw_addr_i <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    chk({31'h0, tw_disconnect_o}, {31'h0, exp});
  endtask : tw
  task automatic ur(input bridge_ctrl_pkg::read_cmd_e c, input logic pf);
    @(posedge clock_i);
    ur_valid_i <= 1'b1;
    ur_cmd_i <= c;
    @(posedge clock_i);
    @(negedge clock_i);
    chk({28'h0, ur_prefetch_o, ur_single_dword_o, ur_forward_be_o, ur_disconnect_first_o}, pf ? 32'h8 : 32'h7);
  endtask : ur
  initial begin
    repeat (2000) @(posedge clock_i);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(6'h10, 32'h0);
    rd(6'h38, 32'h0);
    cfg(1'b1, 6'h10, 4'h0, 32'hffff_feff);
    rd(6'h10, 32'h0000_0612);
    cfg(1'b1, 6'h10, 4'he, 32'h0);
    rd(6'h10, 32'h0000_0600);
    cfg(1'b1, 6'h38, 4'h0, 32'hffff_ffff);
    rd(6'h38, 32'h0);
    $display("register access test done");
    for (int m = 0; m < 4; m++) begin
      cfg(1'b1, 6'h10, 4'hd, 32'(m) << 9);
      // byte enables trail the mode by a cycle
      @(negedge clock_i);
      chk({27'h0, test_mode_o, counter_byte_en_o}, (m << 3) | ((m == 0) ? 7 : (m == 1) ? 2 : (m == 2) ? 4 : 1));
    end
    $display("test mode test done");
    tw(1'b0, 12'h00c, 1'b0);
    tw(1'b0, 12'hffc, 1'b1);
    tw(1'b1, 12'h010, 1'b1);
    cfg(1'b1, 6'h10, 4'he, 32'h2);
    tw(1'b0, 12'h00c, 1'b1);
    tw(1'b0, 12'h010, 1'b0);
    @(posedge clock_i);
    tw_active_i <= 1'b0;
    ur(bridge_ctrl_pkg::RD_MEM, 1'b1);
    cfg(1'b1, 6'h10, 4'he, 32'h10);
    ur(bridge_ctrl_pkg::RD_MEM, 1'b0);
    ur(bridge_ctrl_pkg::RD_MEM_LINE, 1'b1);
    ur(bridge_ctrl_pkg::RD_MEM_MULT, 1'b1);
    @(posedge clock_i);
    ur_valid_i <= 1'b0;
    $display("traffic policy test done");
    cfg(1'b1, 6'h10, 4'hd, 32'h0);
    chk({30'h0, chip_reset_o, sec_rst_l_o}, 32'h1);
    cfg(1'b1, 6'h10, 4'hd, 32'h100);
    chk({30'h0, sec_rst_l_o, sec_reset_bit_o}, 32'h1);
    rd(6'h10, 32'h100);
    chk({31'h0, chip_reset_o}, 32'h1);
    repeat (22) @(negedge clock_i);
    rd(6'h10, 32'h0);
    chk({31'h0, chip_reset_o}, 32'h0);
    chk({31'h0, sec_rst_l_o}, 32'h0);
    @(posedge clock_i);
    clear_req <= 1'b1;
    @(posedge clock_i);
    clear_req <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk({30'h0, sec_rst_l_o, sec_reset_bit_o}, 32'h2);
    $display("chip reset test done");
    tally_and_finish();
  end
endmodule : bridge_chip_control_regs_bench
